// [src/gpio_port_map.svh]
// Register map, field positions, reset values for the 8-bit GPIO port.
// Assumes inclusion by the package and the port modules only.
`ifndef GPIO_PORT_MAP_SVH
`define GPIO_PORT_MAP_SVH

`define PORT_WIDTH 8
`define ADDR_WIDTH 2
`define OFFS_PIN_DATA 2'h0
`define OFFS_DIRECTION 2'h1
`define OFFS_ANALOG_SELECT 2'h2
`define DIRECTION_RESET 8'hff
`define ANALOG_SELECT_RESET 8'hff
`define LATCH_RESET 8'h00
`define TIMER_GATE_BIT 0

`endif

// [src/gpio_port_pkg.sv]
// Types shared by the GPIO port modules.
// Assumes gpio_port_map.svh is on the include path.
`include "gpio_port_map.svh"

package gpio_port_pkg;
    typedef logic [`PORT_WIDTH-1:0] port_word_t;
    typedef enum logic [1:0] {
        SEL_PIN_DATA = 2'b00,
        SEL_DIRECTION = 2'b01,
        SEL_ANALOG = 2'b10,
        SEL_NONE = 2'b11
    } reg_sel_t;
endpackage

// [src/pad_if.sv]
// Bundle between the register core and the pad stage.
// Assumes one clock domain; no clocking block.
interface pad_if;
    gpio_port_pkg::port_word_t latch;
    gpio_port_pkg::port_word_t direction;
    gpio_port_pkg::port_word_t analog;
    gpio_port_pkg::port_word_t digital_in;
    modport core (output latch, output direction, output analog,
                  input digital_in);
    modport pad (input latch, input direction, input analog,
                 output digital_in);
endinterface

// [src/gpio_pad_stage.sv]
// Pad stage: registered driver enables and gated digital input buffers.
// Assumes pins are synchronous to the clock.
`include "gpio_port_map.svh"

module gpio_pad_stage (
    input wire logic clk,
    input wire logic arst_n,
    pad_if.pad pads,
    input wire gpio_port_pkg::port_word_t pin_level,
    output gpio_port_pkg::port_word_t pin_out,
    output gpio_port_pkg::port_word_t pin_oe_n
);
    typedef struct packed {
        gpio_port_pkg::port_word_t out;
        gpio_port_pkg::port_word_t oe_n;
    } pad_state_t;

    pad_state_t state;
    pad_state_t next_state;

    // Analog pins have their input buffer off and read as zero
    assign pads.digital_in = pin_level & ~pads.analog;

    always_comb begin
        next_state = state;
        next_state.out = pads.latch;
        // Enable is active low: a set direction bit tristates
        // Analog select is not consulted here
        next_state.oe_n = pads.direction;
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state <= '{out: `LATCH_RESET, oe_n: `DIRECTION_RESET};
        end else begin
            state <= next_state;
        end
    end

    assign pin_out = state.out;
    assign pin_oe_n = state.oe_n;
endmodule

// [src/gpio_port.sv]
// Eight-bit bidirectional GPIO port with direction and analog select.
// Assumes a simple strobe register port and pins synchronous to CLK_IN.
//
// Notes on behaviour
// - Direction bit 1 turns the pin driver off; pin is an input.
// - Direction bit 0 drives the output latch bit onto the pin.
// - Pin data reads return pin levels; writes go to the latch.
// - Writes are read-modify-write built on the sampled pin levels.
// - Direction still controls the driver of an analog pin.
// - Analog pins always read zero through pin data.
// - Analog select 1 disables the digital input buffer.
// - Analog select never affects output; RMW may corrupt the latch.
// - Analog select resets to all ones on every reset.
// - Direction is read/write and resets to all ones.
// - Pin data is eight bits, 1 for high, reset value unknown; the latch here resets to 8'h00.
// - Pins feed cap-sense inputs; pin 0 also feeds the timer gate.
//
// The implementer's own choices: the address map and strobed register access.
`include "gpio_port_map.svh"

module gpio_port (
    // Clock and reset
    input wire logic CLK_IN,
    input wire logic ARST_N_IN,
    // Register port
    input wire logic [`ADDR_WIDTH-1:0] ADDR_IN,
    input wire logic [`PORT_WIDTH-1:0] WDATA_IN,
    input wire logic [`PORT_WIDTH-1:0] WMASK_IN,
    input wire logic WR_IN,
    input wire logic RD_IN,
    output logic [`PORT_WIDTH-1:0] RDATA_OUT,
    // Pins
    input wire logic [`PORT_WIDTH-1:0] PIN_IN,
    output logic [`PORT_WIDTH-1:0] PIN_OUT,
    output logic [`PORT_WIDTH-1:0] PIN_OE_N_OUT,
    // Peripheral taps
    output logic [`PORT_WIDTH-1:0] CAP_SENSE_CHANNEL_OUT,
    output logic TIMER_GATE_INPUT_OUT
);

    ////////////////////////////////////////////////////////////////////
    // State

    typedef struct packed {
        gpio_port_pkg::port_word_t latch;
        gpio_port_pkg::port_word_t direction;
        gpio_port_pkg::port_word_t analog;
        gpio_port_pkg::port_word_t rdata;
        gpio_port_pkg::port_word_t cap_sense;
        logic timer_gate;
    } port_state_t;

    port_state_t state;
    port_state_t next_state;
    pad_if pads ();

    function automatic gpio_port_pkg::reg_sel_t decode(
        input logic [`ADDR_WIDTH-1:0] addr
    );
        case (addr)
            `OFFS_PIN_DATA: decode = gpio_port_pkg::SEL_PIN_DATA;
            `OFFS_DIRECTION: decode = gpio_port_pkg::SEL_DIRECTION;
            `OFFS_ANALOG_SELECT: decode = gpio_port_pkg::SEL_ANALOG;
            default: decode = gpio_port_pkg::SEL_NONE;
        endcase
    endfunction

    // Merge new bits where the mask is set, keep base elsewhere
    function automatic gpio_port_pkg::port_word_t merge(
        input gpio_port_pkg::port_word_t base,
        input gpio_port_pkg::port_word_t data,
        input gpio_port_pkg::port_word_t mask
    );
        merge = (base & ~mask) | (data & mask);
    endfunction

    ////////////////////////////////////////////////////////////////////
    // Next state

    always_comb begin
        next_state = state;
        next_state.rdata = 8'h00;
        if (WR_IN) begin
            case (decode(ADDR_IN))
                gpio_port_pkg::SEL_PIN_DATA: begin
                    // Unmasked bits take the sampled pin value, so an
                    // analog pin's latch bit becomes zero
                    next_state.latch = merge(pads.digital_in, WDATA_IN,
                                             WMASK_IN);
                end
                gpio_port_pkg::SEL_DIRECTION: begin
                    next_state.direction = WDATA_IN;
                end
                gpio_port_pkg::SEL_ANALOG: begin
                    next_state.analog = WDATA_IN;
                end
                default: begin
                    next_state.latch = state.latch;
                end
            endcase
        end
        if (RD_IN) begin
            case (decode(ADDR_IN))
                gpio_port_pkg::SEL_PIN_DATA: begin
                    next_state.rdata = pads.digital_in;
                end
                gpio_port_pkg::SEL_DIRECTION: begin
                    next_state.rdata = state.direction;
                end
                gpio_port_pkg::SEL_ANALOG: begin
                    next_state.rdata = state.analog;
                end
                default: begin
                    next_state.rdata = 8'h00;
                end
            endcase
        end
        // Cap-sense taps see the raw pin, independent of analog select
        next_state.cap_sense = PIN_IN;
        next_state.timer_gate = pads.digital_in[`TIMER_GATE_BIT];
    end

    ////////////////////////////////////////////////////////////////////
    // Registers

    // The latch is nominally unknown after reset; zero is used so the
    // outputs stay defined, software must not rely on it
    always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            state.latch <= `LATCH_RESET;
            state.direction <= `DIRECTION_RESET;
            state.analog <= `ANALOG_SELECT_RESET;
            state.rdata <= 8'h00;
            state.cap_sense <= 8'h00;
            state.timer_gate <= 1'b0;
        end else begin
            state <= next_state;
        end
    end

    assign pads.latch = state.latch;
    assign pads.direction = state.direction;
    assign pads.analog = state.analog;

    ////////////////////////////////////////////////////////////////////
    // Pad stage

    gpio_pad_stage u_pad (
        .clk(CLK_IN),
        .arst_n(ARST_N_IN),
        .pads(pads.pad),
        .pin_level(PIN_IN),
        .pin_out(PIN_OUT),
        .pin_oe_n(PIN_OE_N_OUT)
    );

    assign RDATA_OUT = state.rdata;
    assign CAP_SENSE_CHANNEL_OUT = state.cap_sense;
    assign TIMER_GATE_INPUT_OUT = state.timer_gate;
endmodule

// [test/gpio_port_assertions.sv]
// Checker for the GPIO port register and pin ports.
// Assumes it is bound to gpio_port; one clock domain.
module gpio_port_checker (
    input wire logic CLK_IN, ARST_N_IN, WR_IN, RD_IN, TIMER_GATE_INPUT_OUT,
    input wire logic [1:0] ADDR_IN,
    input wire logic [7:0] WDATA_IN, WMASK_IN, RDATA_OUT, PIN_IN,
    input wire logic [7:0] PIN_OUT, PIN_OE_N_OUT, CAP_SENSE_CHANNEL_OUT
);
    timeunit 1ns / 1ps;
    default clocking cb @(posedge CLK_IN); endclocking
    default disable iff (!ARST_N_IN);
    ////////////////////////////////////////////////////////////////////
    property p_oe; WR_IN && ADDR_IN == 2'h1 |-> ##2
        PIN_OE_N_OUT == $past(WDATA_IN, 2); endproperty
    a_oe: assert property (p_oe) else $error("enable wrong");
    property p_unm; RD_IN && ADDR_IN == 2'h3 |=> RDATA_OUT == 8'h00;
    endproperty
    a_unm: assert property (p_unm) else $error("unmapped read");
    property p_idle; !RD_IN |=> RDATA_OUT == 8'h00; endproperty
    a_idle: assert property (p_idle) else $error("read data lingers");
    property p_rdpin; RD_IN && ADDR_IN == 2'h0 |=>
        (RDATA_OUT & ~$past(PIN_IN)) == 8'h00; endproperty
    a_rdpin: assert property (p_rdpin) else $error("pin read");
    property p_wpin; WR_IN && ADDR_IN == 2'h0 |-> ##2
        ((PIN_OUT ^ $past(WDATA_IN, 2)) & $past(WMASK_IN, 2)) == 8'h00;
    endproperty
    a_wpin: assert property (p_wpin) else $error("latch write");
    property p_cap; $past(ARST_N_IN) |->
        CAP_SENSE_CHANNEL_OUT == $past(PIN_IN); endproperty
    a_cap: assert property (p_cap) else $error("sense tap");
    property p_gate; TIMER_GATE_INPUT_OUT |-> $past(PIN_IN[0]); endproperty
    a_gate: assert property (p_gate) else $error("gate tap");
    property p_rst; $rose(ARST_N_IN) |->
        PIN_OE_N_OUT == 8'hff && PIN_OUT == 8'h00; endproperty
    a_rst: assert property (p_rst) else $error("reset state");
endmodule
bind gpio_port gpio_port_checker u_chk (.CLK_IN, .ARST_N_IN, .ADDR_IN,
    .WDATA_IN, .WMASK_IN, .WR_IN, .RD_IN, .RDATA_OUT, .PIN_IN, .PIN_OUT,
    .PIN_OE_N_OUT, .CAP_SENSE_CHANNEL_OUT, .TIMER_GATE_INPUT_OUT);

// [test/gpio_pin_board.sv]
// Board model: resolves each pad from the port driver and a source.
// Assumes active-low driver enables and one clock.
module gpio_pin_board (
    input wire logic clk_in, ext_en_in,
    input wire logic [7:0] drv_in, oe_n_in, ext_in,
    output logic [7:0] level_out
);
    timeunit 1ns / 1ps;
    logic [7:0] last = 8'h00;
    // A floating pad flips each cycle, so a stale level never reads back
    assign level_out = (~oe_n_in & drv_in) |
        (oe_n_in & (ext_en_in ? ext_in : ~last));
    always_ff @(posedge clk_in) last <= level_out;
endmodule

// [test/gpio_port_tb_top.sv]
// Bench for the GPIO port with a board model on the pins.
// Assumes design, checker and board files are compiled first.
module gpio_port_tb_top;
    timeunit 1ns / 1ps;
    logic clk = 0, rst_n = 0, wr = 0, rd = 0, ext_en = 0, gate;
    logic [1:0] addr = 2'h0;
    logic [7:0] wd = 8'h00, wm = 8'h00, ext = 8'h00, rdata, pin, pout;
    logic [7:0] oe_n, cap;
    int n_mismatch = 0, num_checks = 0;
    always #12.5 clk = ~clk;
    gpio_port DUT (.CLK_IN(clk), .ARST_N_IN(rst_n), .ADDR_IN(addr),
        .WDATA_IN(wd), .WMASK_IN(wm), .WR_IN(wr), .RD_IN(rd),
        .RDATA_OUT(rdata), .PIN_IN(pin), .PIN_OUT(pout),
        .PIN_OE_N_OUT(oe_n), .CAP_SENSE_CHANNEL_OUT(cap),
        .TIMER_GATE_INPUT_OUT(gate));
    gpio_pin_board board (.clk_in(clk), .ext_en_in(ext_en), .drv_in(pout),
        .oe_n_in(oe_n), .ext_in(ext), .level_out(pin));
    ////////////////////////////////////////////////////////////////////
    task chk(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task wr_reg(input logic [1:0] a, input logic [7:0] d, m);
        @(posedge clk);
        {wr, addr, wd, wm} <= {1'b1, a, d, m};
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task rd_reg(input logic [1:0] a, input logic [7:0] e);
        @(posedge clk);
        {rd, addr} <= {1'b1, a};
        @(posedge clk);
        rd <= 1'b0;
        #1 chk(rdata, e);
    endtask
    task t_reset;
        rst_n <= 1'b0;
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        rd_reg(2'h1, 8'hff);
        rd_reg(2'h2, 8'hff);
        rd_reg(2'h0, 8'h00);
        rd_reg(2'h3, 8'h00);
        chk(oe_n, 8'hff);
        $display("t_reset done");
    endtask
    task t_drive;
        wr_reg(2'h2, 8'h00, 8'h00);
        wr_reg(2'h0, 8'h3c, 8'hff);
        wr_reg(2'h1, 8'h00, 8'h00);
        // Driver enable lags the direction write by one edge
        @(posedge clk);
        rd_reg(2'h0, 8'h3c);
        // Unmasked bits reload the pin levels
        wr_reg(2'h0, 8'hff, 8'h0f);
        wr_reg(2'h2, 8'hf0, 8'h00);
        wr_reg(2'h0, 8'h00, 8'h00);
        repeat (2) @(posedge clk);
        #1 chk(pout, 8'h0f);
        chk(oe_n, 8'h00);
        rd_reg(2'h0, 8'h0f);
        $display("t_drive done");
    endtask
    task t_hold;
        wr_reg(2'h1, 8'hff, 8'h00);
        {ext, ext_en} <= {8'h55, 1'b1};
        repeat (2) @(posedge clk);
        #1 chk(cap, 8'h55);
        chk({7'h00, gate}, 8'h01);
        rd_reg(2'h0, 8'h05);
        ext_en <= 1'b0;
        wr_reg(2'h1, 8'h00, 8'h00);
        repeat (2) @(posedge clk);
        #1 chk(pout, 8'h0f);
        $display("t_hold done");
    endtask
    task test_done;
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    initial begin
        t_reset;
        t_drive;
        t_hold;
        t_reset;
        test_done;
    end
endmodule
